//--- design/tlc_block_counter.sv
// Counts acquisition cycles into blocks, blocks into segments and into the event.
// Assumes cycle_tick is a one-cycle pulse per acquisition cycle and start clears all.
`timescale 1ns/1ps
module tlc_block_counter
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// Control
	input  wire logic        start,
	input  wire logic        run,
	input  wire logic        cycle_tick,
	input  wire logic [15:0] cycles_per_block,
	input  wire logic [15:0] blocks,
	// Events
	output logic             block_done,
	output logic             seg_done,
	output logic             event_limit
);

	logic [15:0] cyc_cnt;
	logic [15:0] blk_cnt;
	logic [15:0] evt_cnt;
	logic        blk_end;

	assign blk_end = run && cycle_tick && (cyc_cnt + 16'h0001 == cycles_per_block);

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b || start)
			cyc_cnt <= 16'h0000;
		else if (blk_end)
			cyc_cnt <= 16'h0000;
		else if (run && cycle_tick)
			cyc_cnt <= cyc_cnt + 16'h0001;
	end

	// Segment length equals the block count, then wraps for a re-arm
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b || start)
			blk_cnt <= 16'h0000;
		else if (blk_end)
			blk_cnt <= (blk_cnt + 16'h0001 == blocks) ? 16'h0000 : blk_cnt + 16'h0001;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b || start)
			evt_cnt <= 16'h0000;
		else if (blk_end)
			evt_cnt <= evt_cnt + 16'h0001;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			block_done  <= 1'b0;
			seg_done    <= 1'b0;
			event_limit <= 1'b0;
		end
		else
		begin
			block_done  <= blk_end && !start;
			seg_done    <= blk_end && !start && (blk_cnt + 16'h0001 == blocks);
			event_limit <= blk_end && !start &&
				(evt_cnt + 16'h0001 == tlc_pkg::BLOCKS_MAX);
		end
	end

	property p_seg_after_blocks;
		@(posedge sys_clk) disable iff (!rst_b)
		seg_done |-> ($past(blk_cnt) + 16'h0001 == blocks);
	endproperty
	a_seg_after_blocks: assert property (p_seg_after_blocks) else $error("early segment end");

endmodule : tlc_block_counter

//--- design/tlc_pkg.sv
// Constants, register map and state type for the trigger and logging control block.
// Assumes one clock (sys_clk, 100 MHz) and a plain register port with 16-bit data.
//
// Notes on behaviour
// - Always mode records straight after reset
// - Never mode records nothing at all
// - Triggered mode starts on trigger, stops per stop
// - Stop count is in 32k-sample parameter blocks
// - Block count is never below two
// - Until-full mode records until card is full
// - Trigger still active re-arms equal length segment
// - Segment lasts blocks times cycles per block
// - Event closes and restarts at 65535 blocks
// - Analog trigger needs value inside window
// - Analog compare is unsigned sixteen bit
// - Digital trigger compares each bit with mask
// - Mask bits AND by default, OR optional
// - Triggers ANDed, disabled counts active unless both
// - Only 16-bit parameters act as trigger sources
package tlc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL        = 4'h0;
	localparam logic [3:0] OFS_BLOCKS      = 4'h1;
	localparam logic [3:0] OFS_CYC_PER_BLK = 4'h2;
	localparam logic [3:0] OFS_A_SEL       = 4'h3;
	localparam logic [3:0] OFS_A_LOW       = 4'h4;
	localparam logic [3:0] OFS_A_HIGH      = 4'h5;
	localparam logic [3:0] OFS_A_CARE      = 4'h6;
	localparam logic [3:0] OFS_A_VALUE     = 4'h7;
	localparam logic [3:0] OFS_B_SEL       = 4'h8;
	localparam logic [3:0] OFS_B_LOW       = 4'h9;
	localparam logic [3:0] OFS_B_HIGH      = 4'ha;
	localparam logic [3:0] OFS_B_CARE      = 4'hb;
	localparam logic [3:0] OFS_B_VALUE     = 4'hc;
	localparam logic [3:0] OFS_STATUS      = 4'hd;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_UNTIL_FULL = 2;
	localparam int CTRL_A_EN       = 3;
	localparam int CTRL_A_DIGITAL  = 4;
	localparam int CTRL_A_OR       = 5;
	localparam int CTRL_B_EN       = 6;
	localparam int CTRL_B_DIGITAL  = 7;
	localparam int CTRL_B_OR       = 8;
	localparam int CTRL_WIDTH      = 9;

	// Log condition codes
	localparam logic [1:0] MODE_ALWAYS    = 2'h0;
	localparam logic [1:0] MODE_NEVER     = 2'h1;
	localparam logic [1:0] MODE_TRIGGERED = 2'h2;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [8:0]  CTRL_RESET    = 9'h000;
	localparam logic [15:0] BLOCKS_MIN    = 16'h0002;
	localparam logic [15:0] BLOCKS_MAX    = 16'hffff;
	localparam logic [15:0] CYC_RESET     = 16'h0001;
	localparam logic [15:0] BLOCK_SAMPLES = 16'h8000;
	localparam logic [15:0] WORD_RESET    = 16'h0000;

	typedef enum logic [1:0] {st_idle, st_record, st_full} tlc_state_type;

endpackage : tlc_pkg

//--- design/tlc_top.sv
// Top of the trigger and logging control block: registers, two triggers, log state machine.
// Assumes backplane strobes are on sys_clk; card_full comes from a pin and is synchronised.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module tlc_top
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [15:0] reg_rdata,
	// Backplane parameter stream
	input  wire logic        param_valid,
	input  wire logic        param_is16,
	input  wire logic [7:0]  param_id,
	input  wire logic [15:0] param_data,
	input  wire logic        acq_cycle_tick,
	// Storage card
	input  wire logic        card_full,
	// Logging outputs
	output logic             log_enable,
	output logic             event_start,
	output logic             event_close,
	output logic             block_mark
);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [8:0]  ctrl;
	logic [15:0] blocks;
	logic [15:0] cyc_per_blk;
	logic [7:0]  a_sel;
	logic [15:0] a_low;
	logic [15:0] a_high;
	logic [15:0] a_care;
	logic [15:0] a_value;
	logic [7:0]  b_sel;
	logic [15:0] b_low;
	logic [15:0] b_high;
	logic [15:0] b_care;
	logic [15:0] b_value;
	logic [7:0]  event_count;

	logic                   card_meta;
	logic                   card_full_s;
	tlc_pkg::tlc_state_type state;
	tlc_pkg::tlc_state_type next_state;
	logic                   next_start;
	logic                   next_close;
	logic                   a_hit;
	logic                   b_hit;
	logic                   trig_go;
	logic                   blk_done;
	logic                   seg_done;
	logic                   evt_limit;
	logic [1:0]             mode;
	logic                   until_full;

	assign mode       = ctrl[tlc_pkg::CTRL_MODE_LSB +: 2];
	assign until_full = ctrl[tlc_pkg::CTRL_UNTIL_FULL];

	// Count writes below the minimum are raised to it, not refused
	function automatic logic [15:0] clamp_blocks(input logic [15:0] v);
		clamp_blocks = (v < tlc_pkg::BLOCKS_MIN) ? tlc_pkg::BLOCKS_MIN : v;
	endfunction : clamp_blocks

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			ctrl        <= tlc_pkg::CTRL_RESET;
			blocks      <= tlc_pkg::BLOCKS_MIN;
			cyc_per_blk <= tlc_pkg::CYC_RESET;
			a_sel       <= 8'h00;
			a_low       <= tlc_pkg::WORD_RESET;
			a_high      <= tlc_pkg::WORD_RESET;
			a_care      <= tlc_pkg::WORD_RESET;
			a_value     <= tlc_pkg::WORD_RESET;
			b_sel       <= 8'h00;
			b_low       <= tlc_pkg::WORD_RESET;
			b_high      <= tlc_pkg::WORD_RESET;
			b_care      <= tlc_pkg::WORD_RESET;
			b_value     <= tlc_pkg::WORD_RESET;
		end
		else if (reg_write)
		begin
			case (reg_addr)
				tlc_pkg::OFS_CTRL:        ctrl        <= reg_wdata[8:0];
				tlc_pkg::OFS_BLOCKS:      blocks      <= clamp_blocks(reg_wdata);
				tlc_pkg::OFS_CYC_PER_BLK: cyc_per_blk <= (reg_wdata == 16'h0000) ?
					tlc_pkg::CYC_RESET : reg_wdata;
				tlc_pkg::OFS_A_SEL:       a_sel       <= reg_wdata[7:0];
				tlc_pkg::OFS_A_LOW:       a_low       <= reg_wdata;
				tlc_pkg::OFS_A_HIGH:      a_high      <= reg_wdata;
				tlc_pkg::OFS_A_CARE:      a_care      <= reg_wdata;
				tlc_pkg::OFS_A_VALUE:     a_value     <= reg_wdata;
				tlc_pkg::OFS_B_SEL:       b_sel       <= reg_wdata[7:0];
				tlc_pkg::OFS_B_LOW:       b_low       <= reg_wdata;
				tlc_pkg::OFS_B_HIGH:      b_high      <= reg_wdata;
				tlc_pkg::OFS_B_CARE:      b_care      <= reg_wdata;
				tlc_pkg::OFS_B_VALUE:     b_value     <= reg_wdata;
				default:                  ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read port, data valid only in the cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b || !reg_read)
			reg_rdata <= 16'h0000;
		else
		begin
			case (reg_addr)
				tlc_pkg::OFS_CTRL:        reg_rdata <= {7'h00, ctrl};
				tlc_pkg::OFS_BLOCKS:      reg_rdata <= blocks;
				tlc_pkg::OFS_CYC_PER_BLK: reg_rdata <= cyc_per_blk;
				tlc_pkg::OFS_A_SEL:       reg_rdata <= {8'h00, a_sel};
				tlc_pkg::OFS_A_LOW:       reg_rdata <= a_low;
				tlc_pkg::OFS_A_HIGH:      reg_rdata <= a_high;
				tlc_pkg::OFS_A_CARE:      reg_rdata <= a_care;
				tlc_pkg::OFS_A_VALUE:     reg_rdata <= a_value;
				tlc_pkg::OFS_B_SEL:       reg_rdata <= {8'h00, b_sel};
				tlc_pkg::OFS_B_LOW:       reg_rdata <= b_low;
				tlc_pkg::OFS_B_HIGH:      reg_rdata <= b_high;
				tlc_pkg::OFS_B_CARE:      reg_rdata <= b_care;
				tlc_pkg::OFS_B_VALUE:     reg_rdata <= b_value;
				tlc_pkg::OFS_STATUS:      reg_rdata <= {2'h0, state, a_hit, b_hit,
					card_full_s, log_enable, event_count};
				default:                  reg_rdata <= 16'h0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Card full pin synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			card_meta   <= 1'b0;
			card_full_s <= 1'b0;
		end
		else
		begin
			card_meta   <= card_full;
			card_full_s <= card_meta;
		end
	end

	// ----------------------------------------------------------------
	// Triggers
	// ----------------------------------------------------------------
	tlc_trigger u_trig_a
	(
		.sys_clk     (sys_clk),
		.rst_b       (rst_b),
		.digital     (ctrl[tlc_pkg::CTRL_A_DIGITAL]),
		.or_mode     (ctrl[tlc_pkg::CTRL_A_OR]),
		.sel         (a_sel),
		.low         (a_low),
		.high        (a_high),
		.care        (a_care),
		.value       (a_value),
		.param_valid (param_valid),
		.param_is16  (param_is16),
		.param_id    (param_id),
		.param_data  (param_data),
		.hit         (a_hit)
	);

	tlc_trigger u_trig_b
	(
		.sys_clk     (sys_clk),
		.rst_b       (rst_b),
		.digital     (ctrl[tlc_pkg::CTRL_B_DIGITAL]),
		.or_mode     (ctrl[tlc_pkg::CTRL_B_OR]),
		.sel         (b_sel),
		.low         (b_low),
		.high        (b_high),
		.care        (b_care),
		.value       (b_value),
		.param_valid (param_valid),
		.param_is16  (param_is16),
		.param_id    (param_id),
		.param_data  (param_data),
		.hit         (b_hit)
	);

	// Both off gives no trigger; a single disabled one reads as active
	assign trig_go = (ctrl[tlc_pkg::CTRL_A_EN] || ctrl[tlc_pkg::CTRL_B_EN]) &&
		(!ctrl[tlc_pkg::CTRL_A_EN] || a_hit) &&
		(!ctrl[tlc_pkg::CTRL_B_EN] || b_hit);

	tlc_block_counter u_count
	(
		.sys_clk          (sys_clk),
		.rst_b            (rst_b),
		.start            (next_start),
		.run              (state == tlc_pkg::st_record),
		.cycle_tick       (acq_cycle_tick),
		.cycles_per_block (cyc_per_blk),
		.blocks           (blocks),
		.block_done       (blk_done),
		.seg_done         (seg_done),
		.event_limit      (evt_limit)
	);

	// ----------------------------------------------------------------
	// Log state machine
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_start = 1'b0;
		next_close = 1'b0;
		case (state)
			tlc_pkg::st_idle:
			begin
				if (card_full_s)
					next_state = tlc_pkg::st_full;
				else if (mode == tlc_pkg::MODE_ALWAYS ||
					(mode == tlc_pkg::MODE_TRIGGERED && trig_go))
				begin
					next_state = tlc_pkg::st_record;
					next_start = 1'b1;
				end
			end
			tlc_pkg::st_record:
			begin
				if (card_full_s)
				begin
					next_state = tlc_pkg::st_full;
					next_close = 1'b1;
				end
				else if (mode != tlc_pkg::MODE_ALWAYS && mode != tlc_pkg::MODE_TRIGGERED)
				begin
					next_state = tlc_pkg::st_idle;
					next_close = 1'b1;
				end
				else if (evt_limit)
				begin
					next_close = 1'b1;
					next_start = 1'b1;
				end
				else if (seg_done && mode == tlc_pkg::MODE_TRIGGERED &&
					!until_full && !trig_go)
				begin
					next_state = tlc_pkg::st_idle;
					next_close = 1'b1;
				end
			end
			tlc_pkg::st_full:
			begin
				// The open block at the fill point may be incomplete
				if (!card_full_s)
					next_state = tlc_pkg::st_idle;
			end
			default:
				next_state = tlc_pkg::st_idle;
		endcase
		if (mode == tlc_pkg::MODE_NEVER)
			next_start = 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			state <= tlc_pkg::st_idle;
		else
			state <= next_state;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			log_enable  <= 1'b0;
			event_start <= 1'b0;
			event_close <= 1'b0;
			block_mark  <= 1'b0;
		end
		else
		begin
			log_enable  <= (next_state == tlc_pkg::st_record);
			event_start <= next_start;
			event_close <= next_close;
			block_mark  <= blk_done;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			event_count <= 8'h00;
		else if (next_start)
			event_count <= event_count + 8'h01;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_seg_end_idle;
		state == tlc_pkg::st_record && mode == tlc_pkg::MODE_TRIGGERED && !until_full &&
			seg_done && !evt_limit && !card_full_s;
	endsequence

	property p_never;
		@(posedge sys_clk) disable iff (!rst_b)
		(mode == tlc_pkg::MODE_NEVER) |=> !log_enable;
	endproperty
	a_never: assert property (p_never) else $error("recording in never mode");

	property p_always;
		@(posedge sys_clk) disable iff (!rst_b)
		(state == tlc_pkg::st_idle && mode == tlc_pkg::MODE_ALWAYS && !card_full_s)
			|=> log_enable && event_start;
	endproperty
	a_always: assert property (p_always) else $error("always mode did not start");

	property p_trig_start;
		@(posedge sys_clk) disable iff (!rst_b)
		(state == tlc_pkg::st_idle && mode == tlc_pkg::MODE_TRIGGERED && !card_full_s)
			|=> (log_enable == $past(trig_go));
	endproperty
	a_trig_start: assert property (p_trig_start) else $error("trigger start wrong");

	property p_stop;
		@(posedge sys_clk) disable iff (!rst_b)
		(s_seg_end_idle ##0 !trig_go) |=> (!log_enable && event_close) ##1
			(!log_enable || event_start);
	endproperty
	a_stop: assert property (p_stop) else $error("no stop after segment");

	property p_rearm;
		@(posedge sys_clk) disable iff (!rst_b)
		(s_seg_end_idle ##0 trig_go) |=> log_enable && !event_close;
	endproperty
	a_rearm: assert property (p_rearm) else $error("no re-arm");

	property p_min_blocks;
		@(posedge sys_clk) disable iff (!rst_b)
		blocks >= tlc_pkg::BLOCKS_MIN;
	endproperty
	a_min_blocks: assert property (p_min_blocks) else $error("block count below two");

	property p_limit;
		@(posedge sys_clk) disable iff (!rst_b)
		(state == tlc_pkg::st_record && evt_limit && !card_full_s &&
			(mode == tlc_pkg::MODE_ALWAYS || mode == tlc_pkg::MODE_TRIGGERED))
			|=> event_close && event_start && log_enable;
	endproperty
	a_limit: assert property (p_limit) else $error("event not split");

	property p_full;
		@(posedge sys_clk) disable iff (!rst_b)
		card_full_s |=> !log_enable;
	endproperty
	a_full: assert property (p_full) else $error("recording on full card");

	property p_combine;
		@(posedge sys_clk) disable iff (!rst_b)
		(!ctrl[tlc_pkg::CTRL_A_EN] && !ctrl[tlc_pkg::CTRL_B_EN]) |-> !trig_go;
	endproperty
	a_combine: assert property (p_combine) else $error("trigger with both disabled");

endmodule : tlc_top

//--- design/tlc_trigger.sv
// One trigger channel: window compare or bit-mask compare on a selected parameter.
// Assumes backplane samples arrive on sys_clk as one-cycle valid strobes.
`timescale 1ns/1ps
module tlc_trigger
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// Configuration
	input  wire logic        digital,
	input  wire logic        or_mode,
	input  wire logic [7:0]  sel,
	input  wire logic [15:0] low,
	input  wire logic [15:0] high,
	input  wire logic [15:0] care,
	input  wire logic [15:0] value,
	// Backplane samples
	input  wire logic        param_valid,
	input  wire logic        param_is16,
	input  wire logic [7:0]  param_id,
	input  wire logic [15:0] param_data,
	// Result
	output logic             hit
);

	logic        take;
	logic [15:0] bit_ok;
	logic        analog_hit;
	logic        digital_hit;

	// Narrower parameters are ignored, the last result stands
	assign take = param_valid && param_is16 && (param_id == sel);
	// Unsigned window, both bound tests must hold
	assign analog_hit = (param_data >= low) && (param_data <= high);
	// Per-bit match; ignored positions never count
	assign bit_ok = ~(param_data ^ value) & care;
	assign digital_hit = or_mode ? (|bit_ok) : (bit_ok == care);

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			hit <= 1'b0;
		else if (take)
			hit <= digital ? digital_hit : analog_hit;
	end

	property p_analog_window;
		@(posedge sys_clk) disable iff (!rst_b)
		(take && !digital) |=> (hit == ($past(param_data) >= $past(low) &&
			$past(param_data) <= $past(high)));
	endproperty
	a_analog_window: assert property (p_analog_window) else $error("window result wrong");

	property p_narrow_ignored;
		@(posedge sys_clk) disable iff (!rst_b)
		(param_valid && !param_is16) |=> $stable(hit);
	endproperty
	a_narrow_ignored: assert property (p_narrow_ignored) else $error("narrow sample used");

endmodule : tlc_trigger

//--- sim/tlc_backplane_model.sv
// Backplane parameter source and card-full pin for the logging control bench.
// Assumes the bench calls send() and set_full(); acquisition ticks run free.
`timescale 1ns/1ps
module tlc_backplane_model
(
	// Clock
	input  wire logic        sys_clk,
	// Backplane
	output logic             param_valid,
	output logic             param_is16,
	output logic [7:0]       param_id,
	output logic [15:0]      param_data,
	output logic             acq_cycle_tick,
	// Card
	output logic             card_full
);
	logic [7:0]  id_q;
	logic [15:0] data_q;
	logic [1:0]  tick_cnt;
	logic        is16_q;
	// Fast ticks let a full-size event fit in a short run
	logic        fast_tick;

	initial
	begin
		param_valid    = 1'b0;
		is16_q         = 1'b0;
		fast_tick      = 1'b0;
		id_q           = 8'h00;
		data_q         = 16'h0000;
		tick_cnt       = 2'h0;
		acq_cycle_tick = 1'b0;
		card_full      = 1'b0;
	end

	// Released lines show the inverse, so a stale value cannot pass for a live one
	assign param_is16 = param_valid ? is16_q : ~is16_q;
	assign param_id   = param_valid ? id_q : ~id_q;
	assign param_data = param_valid ? data_q : ~data_q;

	// One acquisition cycle every four clocks
	always @(posedge sys_clk)
	begin
		tick_cnt       <= tick_cnt + 2'h1;
		acq_cycle_tick <= (tick_cnt == 2'h3) || fast_tick;
	end

	// One sample per strobe; 32-bit values would come as two 16-bit words
	task automatic send(input logic is16, input logic [7:0] id, input logic [15:0] dat);
		@(posedge sys_clk);
		param_valid <= 1'b1;
		is16_q      <= is16;
		id_q        <= id;
		data_q      <= dat;
		@(posedge sys_clk);
		param_valid <= 1'b0;
	endtask : send

	task automatic set_full(input logic v);
		@(posedge sys_clk);
		card_full <= v;
	endtask : set_full
endmodule : tlc_backplane_model

//--- sim/tlc_top_tb.sv
// Self-checking bench for the trigger and logging control top.
// Assumes the backplane model above and the register map of the package.
`timescale 1ns/1ps
module tlc_top_tb;
	logic        sys_clk;
	logic        rst_b;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_write;
	logic        reg_read;
	logic [15:0] reg_rdata;
	wire         param_valid, param_is16, acq_cycle_tick, card_full;
	wire  [7:0]  param_id;
	wire  [15:0] param_data;
	logic        log_enable, event_start, event_close, block_mark;
	integer      failures, tests_run, seed, cycles, nblk, ncls, nlast, i, j, k;
	logic [15:0] rd, lo, hi, d, v, c;
	logic [15:0] c_aen, c_bdig, c_bor, c_full;

	tlc_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.param_valid(param_valid), .param_is16(param_is16), .param_id(param_id),
		.param_data(param_data), .acq_cycle_tick(acq_cycle_tick), .card_full(card_full),
		.log_enable(log_enable), .event_start(event_start), .event_close(event_close),
		.block_mark(block_mark));
	tlc_backplane_model src (.sys_clk(sys_clk), .param_valid(param_valid),
		.param_is16(param_is16), .param_id(param_id), .param_data(param_data),
		.acq_cycle_tick(acq_cycle_tick), .card_full(card_full));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// Monitors and timeout
	// ----------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (event_start) nblk <= 0;
		else if (block_mark) nblk <= nblk + 1;
		if (event_close) ncls <= ncls + 1;
		// At a split the closing block marks in the same cycle as the new start
		if (event_close) nlast <= nblk + block_mark;
		if (cycles == 75000)
		begin
			failures = failures + 1;
			finish_test;
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			failures = failures + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test

	task automatic wr(input logic [3:0] a, input logic [15:0] dat);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= dat;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 rd = reg_rdata;
	endtask : rdr

	function automatic logic f_win(input logic [15:0] x, input logic [15:0] l, input logic [15:0] h);
		return x >= l && x <= h;
	endfunction : f_win

	function automatic logic f_dig(input logic [15:0] x, input logic [15:0] m,
		input logic [15:0] cr, input logic o);
		logic [15:0] ok;
		ok = ~(x ^ m) & cr;
		return o ? |ok : ok == cr;
	endfunction : f_dig

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		seed = 32'hde8d;
		failures = 0;
		tests_run = 0;
		cycles = 0;
		nblk = 0;
		ncls = 0;
		c_aen = 16'h1 << tlc_pkg::CTRL_A_EN;
		c_bdig = 16'h1 << tlc_pkg::CTRL_B_DIGITAL;
		c_bor = 16'h1 << tlc_pkg::CTRL_B_OR;
		c_full = 16'h1 << tlc_pkg::CTRL_UNTIL_FULL;
		rst_b = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 check(log_enable, 16'h1);
		rdr(tlc_pkg::OFS_CTRL);
		check(rd, 16'h0000);
		rdr(tlc_pkg::OFS_BLOCKS);
		check(rd, tlc_pkg::BLOCKS_MIN);
		rdr(tlc_pkg::OFS_CYC_PER_BLK);
		check(rd, tlc_pkg::CYC_RESET);
		rdr(4'he);
		check(rd, 16'h0000);
		wr(tlc_pkg::OFS_BLOCKS, 16'h0001);
		rdr(tlc_pkg::OFS_BLOCKS);
		check(rd, 16'h0002);
		wr(tlc_pkg::OFS_CYC_PER_BLK, 16'h0000);
		rdr(tlc_pkg::OFS_CYC_PER_BLK);
		check(rd, 16'h0001);
		wr(tlc_pkg::OFS_CTRL, 16'hffff);
		rdr(tlc_pkg::OFS_CTRL);
		check(rd, 16'h01ff);
		wr(tlc_pkg::OFS_CTRL, {14'h0, tlc_pkg::MODE_NEVER});
		wr(tlc_pkg::OFS_CYC_PER_BLK, 16'h0003);
		wr(tlc_pkg::OFS_A_SEL, 16'h0005);
		wr(tlc_pkg::OFS_B_SEL, 16'h0009);
		$display("test registers done");
		// Window compare with edges, ignored widths and foreign ids
		for (i = 0; i < 20; i++)
		begin
			lo = $random(seed);
			hi = lo + ($random(seed) & 16'h3fff);
			case (i % 5)
				0: d = lo;
				1: d = hi;
				2: d = lo - 16'h1;
				3: d = hi + 16'h1;
				default: d = $random(seed);
			endcase
			wr(tlc_pkg::OFS_A_LOW, lo);
			wr(tlc_pkg::OFS_A_HIGH, hi);
			src.send(1'b1, 8'h05, d);
			src.send(1'b0, 8'h05, ~d);
			src.send(1'b1, 8'h06, ~d);
			rdr(tlc_pkg::OFS_STATUS);
			check(rd[11], f_win(d, lo, hi));
		end
		// Mask compare, AND and OR combining, ignored bits
		for (i = 0; i < 24; i++)
		begin
			v = $random(seed);
			c = (i % 4 == 1) ? 16'h0000 : $random(seed);
			d = (i % 4 == 0) ? v : (i % 4 == 3) ? ~v : $random(seed);
			wr(tlc_pkg::OFS_CTRL, {14'h0, tlc_pkg::MODE_NEVER} | c_bdig | (i[2] ? c_bor : 16'h0));
			wr(tlc_pkg::OFS_B_VALUE, v);
			wr(tlc_pkg::OFS_B_CARE, c);
			src.send(1'b1, 8'h09, d);
			rdr(tlc_pkg::OFS_STATUS);
			check(rd[10], f_dig(d, v, c, i[2]));
		end
		check(log_enable, 16'h0);
		$display("test trigger compare done");
		// Triggered start, re-arm while active, stop on segment edge
		wr(tlc_pkg::OFS_A_LOW, 16'h1000);
		wr(tlc_pkg::OFS_A_HIGH, 16'h2000);
		wr(tlc_pkg::OFS_CTRL, {14'h0, tlc_pkg::MODE_TRIGGERED});
		src.send(1'b1, 8'h05, 16'h1800);
		repeat (6) @(posedge sys_clk);
		#1 check(log_enable, 16'h0);
		wr(tlc_pkg::OFS_CTRL, {14'h0, tlc_pkg::MODE_TRIGGERED} | c_aen);
		@(posedge sys_clk);
		#1 check(event_start, 16'h1);
		repeat (3) @(posedge sys_clk);
		#1 check(log_enable, 16'h1);
		repeat (80) @(posedge sys_clk);
		#1 check(log_enable, 16'h1);
		k = ncls;
		src.send(1'b1, 8'h05, 16'h0000);
		for (j = 0; j < 300 && ncls == k; j++) @(posedge sys_clk);
		repeat (2) @(posedge sys_clk);
		#1 check(log_enable, 16'h0);
		check(nblk % 2, 16'h0);
		check(nblk > 2, 16'h1);
		$display("test triggered segments done");
		// Until full keeps going after the trigger drops; the card stops it
		wr(tlc_pkg::OFS_CTRL, {14'h0, tlc_pkg::MODE_TRIGGERED} | c_aen | c_full);
		src.send(1'b1, 8'h05, 16'h1800);
		src.send(1'b1, 8'h05, 16'h0000);
		repeat (100) @(posedge sys_clk);
		#1 check(log_enable, 16'h1);
		k = ncls;
		src.set_full(1'b1);
		repeat (6) @(posedge sys_clk);
		#1 check(log_enable, 16'h0);
		check(ncls - k, 16'h1);
		rdr(tlc_pkg::OFS_STATUS);
		check(rd[13:12], 16'h2);
		src.set_full(1'b0);
		repeat (6) @(posedge sys_clk);
		$display("test until full done");
		// Event split at the block limit, one acquisition cycle per clock
		wr(tlc_pkg::OFS_CYC_PER_BLK, 16'h0001);
		src.fast_tick <= 1'b1;
		wr(tlc_pkg::OFS_CTRL, {14'h0, tlc_pkg::MODE_ALWAYS});
		k = ncls;
		for (j = 0; j < 70000 && ncls == k; j++) @(posedge sys_clk);
		#1 check(nlast, tlc_pkg::BLOCKS_MAX);
		check(log_enable, 16'h1);
		check(ncls - k, 16'h1);
		$display("test event split done");
		finish_test;
	end
endmodule : tlc_top_tb
